// ===== rtl/fdc_map.svh
// constants for the depth-cascade fifo device
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH
`define FDC_DATA_W 18
`define FDC_OFS_W 12
`define FDC_DEPTH 64
`define FDC_OFS_DEFAULT 12'h007
`endif

// ===== rtl/fdc_pkg.sv
// types for the depth-cascade fifo device
`include "fdc_map.svh"
package fdc_pkg;
  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic almost_full_n;
    logic almost_empty_n;
  } fdc_flags_t;
  typedef enum logic [1:0] {
    FDC_OWN_NONE = 2'b00,
    FDC_OWN_HELD = 2'b01
  } fdc_own_t;
endpackage

// ===== rtl/fdc_cascade.sv
// one cascadable fifo device with write and read token ring logic
`timescale 1ns/10ps
`include "fdc_map.svh"
module fdc_cascade #(
  parameter int DEPTH = `FDC_DEPTH,
  parameter int DW = `FDC_DATA_W,
  parameter int OW = `FDC_OFS_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // cascade
  input wire logic first_device_select,
  input wire logic write_token_in,
  input wire logic read_token_in,
  output logic write_token_out,
  output logic read_token_out,
  // write side
  input wire logic write_en_n,
  input wire logic offset_load,
  input wire logic [DW-1:0] data_in,
  // read side
  input wire logic read_en_n,
  output logic [DW-1:0] data_out,
  output logic data_out_oe,
  // flags
  output fdc_pkg::fdc_flags_t flags
);
  import fdc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  // pin inputs: bit positions in the synchroniser vector
  localparam int SY_FIRST = 5;
  localparam int SY_WTOK = 4;
  localparam int SY_RTOK = 3;
  localparam int SY_WEN = 2;
  localparam int SY_REN = 1;
  localparam int SY_LOAD = 0;
  localparam int NSY = 6;
  wire logic [NSY-1:0] pin_raw = {first_device_select, write_token_in, read_token_in,
    write_en_n, read_en_n, offset_load};
  wire logic [NSY-1:0] sy2;

  // two flip-flops per pin; only the second stage reads the first
  for (genvar gi = 0; gi < NSY; gi++) begin : g_sync
    logic s1_r;
    logic s2_r;
    always_ff @(posedge clk) begin
      s1_r <= pin_raw[gi];
      s2_r <= s1_r;
    end
    assign sy2[gi] = s2_r;
  end

  // synchronised pin levels, enables turned active high
  wire logic first_n_s = sy2[SY_FIRST];
  wire logic wtok_in_s = sy2[SY_WTOK];
  wire logic rtok_in_s = sy2[SY_RTOK];
  wire logic wen_s = ~sy2[SY_WEN];
  wire logic ren_s = ~sy2[SY_REN];
  wire logic ld_s = sy2[SY_LOAD];

  // write data delayed to stay in step with the synchronised enable
  logic [DW-1:0] d1_r;
  logic [DW-1:0] d2_r;
  always_ff @(posedge clk) begin
    d1_r <= data_in;
    d2_r <= d1_r;
  end

  // storage and state
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic [OW-1:0] ofs_e_r, ofs_f_r;
  logic ofs_sel_r, ofs_rsel_r;
  fdc_own_t wown_r, rown_r;
  logic init_r;
  logic wtok_d_r, rtok_d_r;

  // decode
  wire logic wown = (wown_r == FDC_OWN_HELD);
  wire logic rown = (rown_r == FDC_OWN_HELD);
  wire logic full = (cnt_r == DEPTH_C);
  wire logic empty = (cnt_r == '0);
  wire logic prog_wr = ld_s & wen_s;
  wire logic prog_rd = ld_s & ren_s;
  wire logic do_wr = ~ld_s & wen_s & wown & ~full;
  wire logic do_rd = ~ld_s & ren_s & rown & ~empty;
  wire logic cnt_full_nxt = (cnt_r + (AW+1)'(1) == DEPTH_C);
  wire logic wpass = do_wr & cnt_full_nxt;
  wire logic rpass = do_rd & (cnt_r == (AW+1)'(1)) & ~do_wr;
  wire logic wtok_rise = wtok_in_s & ~wtok_d_r;
  wire logic rtok_rise = rtok_in_s & ~rtok_d_r;
  wire logic [AW:0] cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  wire logic [AW:0] ae_lim = (AW+1)'(ofs_e_r);
  wire logic [AW:0] af_lim = DEPTH_C - (AW+1)'(ofs_f_r);

  // reset marker; ownership is settled on the first edge after release
  always_ff @(posedge clk) begin
    if (srst) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  // delayed token levels; reset high so a level held over reset is no new token
  always_ff @(posedge clk) begin
    if (srst) begin
      wtok_d_r <= 1'b1;
      rtok_d_r <= 1'b1;
    end else begin
      wtok_d_r <= wtok_in_s;
      rtok_d_r <= rtok_in_s;
    end
  end

  // write token: first device claims it, passes it on with the write into its last free place
  always_ff @(posedge clk) begin
    if (srst) begin
      wown_r <= FDC_OWN_NONE;
    end else if (init_r) begin
      wown_r <= first_n_s ? FDC_OWN_NONE : FDC_OWN_HELD;
    end else if (wtok_rise) begin
      wown_r <= FDC_OWN_HELD;
    end else if (wpass) begin
      wown_r <= FDC_OWN_NONE;
    end
  end

  // read token: first device claims it, passes it on when emptied
  always_ff @(posedge clk) begin
    if (srst) begin
      rown_r <= FDC_OWN_NONE;
    end else if (init_r) begin
      rown_r <= first_n_s ? FDC_OWN_NONE : FDC_OWN_HELD;
    end else if (rtok_rise) begin
      rown_r <= FDC_OWN_HELD;
    end else if (rpass) begin
      rown_r <= FDC_OWN_NONE;
    end
  end

  // memory, pointers and count
  always_ff @(posedge clk) begin
    if (do_wr) mem[wp_r] <= d2_r;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + AW'(1);
      if (do_rd) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_nxt;
    end
  end

  // offset registers, alternate empty then full
  always_ff @(posedge clk) begin
    if (srst) begin
      ofs_e_r <= `FDC_OFS_DEFAULT;
      ofs_f_r <= `FDC_OFS_DEFAULT;
      ofs_sel_r <= 1'b0;
      ofs_rsel_r <= 1'b0;
    end else begin
      if (prog_wr) begin
        if (ofs_sel_r) ofs_f_r <= d2_r[OW-1:0];
        else ofs_e_r <= d2_r[OW-1:0];
        ofs_sel_r <= ~ofs_sel_r;
      end
      if (prog_rd) ofs_rsel_r <= ~ofs_rsel_r;
    end
  end

  // next flag levels, taken from the count after this edge
  wire logic full_nxt = (cnt_nxt == DEPTH_C);
  wire logic empty_nxt = (cnt_nxt == '0);
  wire logic afull_nxt = (cnt_nxt >= af_lim);
  wire logic aempty_nxt = (cnt_nxt <= ae_lim);
  wire logic [OW-1:0] ofs_rd_sel = ofs_rsel_r ? ofs_f_r : ofs_e_r;

  // read data: fifo word, or offset readback in program mode
  always_ff @(posedge clk) begin
    if (srst) begin
      data_out <= '0;
    end else if (do_rd) begin
      data_out <= mem[rp_r];
    end else if (prog_rd) begin
      data_out <= DW'(ofs_rd_sel);
    end
  end

  // output enable only while owning the read token or reading offsets
  always_ff @(posedge clk) begin
    if (srst) begin
      data_out_oe <= 1'b0;
    end else begin
      data_out_oe <= rown | prog_rd;
    end
  end

  // token pulses, registered one cycle after each pass
  always_ff @(posedge clk) begin
    if (srst) begin
      write_token_out <= 1'b0;
      read_token_out <= 1'b0;
    end else begin
      write_token_out <= wpass;
      read_token_out <= rpass;
    end
  end

  // status flags, active low; almost flags follow the programmed offsets
  always_ff @(posedge clk) begin
    if (srst) begin
      flags.full_n <= 1'b1;
      flags.empty_n <= 1'b0;
      flags.almost_full_n <= 1'b1;
      flags.almost_empty_n <= 1'b0;
    end else begin
      flags.full_n <= ~full_nxt;
      flags.empty_n <= ~empty_nxt;
      flags.almost_full_n <= ~afull_nxt;
      flags.almost_empty_n <= ~aempty_nxt;
    end
  end
endmodule // fdc_cascade

// ===== test/fdc_cascade_properties.sv
// port checks for the cascade fifo device
`timescale 1ns/10ps
module fdc_cascade_properties (
  // watched ports
  input wire logic clk,
  input wire logic srst,
  input wire logic write_token_out,
  input wire logic read_token_out,
  input wire logic data_out_oe,
  input wire fdc_pkg::fdc_flags_t flags
);
  import fdc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // token pulses last one cycle
  sequence s_wp; write_token_out ##1 !write_token_out; endsequence
  sequence s_rp; read_token_out ##1 !read_token_out; endsequence
  chk_wtok_pulse: assert property (write_token_out |-> s_wp)
    else $error("long wtok");
  chk_rtok_pulse: assert property (read_token_out |-> s_rp)
    else $error("long rtok");
  chk_full_wtok: assert property ($fell(flags.full_n) |-> ##[0:1] write_token_out)
    else $error("no wtok");
  chk_rtok_empty: assert property (read_token_out |-> ##[0:1] !flags.empty_n)
    else $error("rtok early");
  chk_oe_drop: assert property (read_token_out |-> ##2 !data_out_oe)
    else $error("oe kept");
  chk_full_af: assert property (!flags.full_n |-> !flags.almost_full_n)
    else $error("full not af");
  chk_empty_ae: assert property (!flags.empty_n |-> !flags.almost_empty_n)
    else $error("empty not ae");
  chk_fill_gap: assert property ($rose(flags.empty_n) |-> flags.full_n)
    else $error("jump to full");
endmodule // fdc_cascade_properties

// ===== test/fdc_ring_model.sv
// rest of the token ring
`timescale 1ns/10ps
module fdc_ring_model #(parameter int DLY = 6) (
  // token link
  input wire logic clk,
  input wire logic srst,
  input wire logic tok_out,
  output logic tok_in
);
  logic [DLY-1:0] pipe_r;
  // other devices hold the token a while
  always_ff @(posedge clk) begin
    if (srst) pipe_r <= '0;
    else pipe_r <= {pipe_r[DLY-2:0], tok_out};
  end
  assign tok_in = pipe_r[DLY-1];
endmodule // fdc_ring_model

// ===== test/fdc_cascade_tb.sv
// bench for the cascade fifo device
`timescale 1ns/10ps
module fdc_cascade_tb;
  import fdc_pkg::*;
  logic clk, srst, fds, wti, rti, wto, rto, wen_n, ld, ren_n, oe;
  logic [17:0] din, dout, wcnt, rcnt;
  logic [2:0] rh;
  fdc_flags_t flags;
  logic [17:0] exp_q[$];
  int errors, compares, seed;
  fdc_cascade #(.DEPTH(8)) i_dut (.clk(clk), .srst(srst), .first_device_select(fds),
    .write_token_in(wti), .read_token_in(rti), .write_token_out(wto), .read_token_out(rto),
    .write_en_n(wen_n), .offset_load(ld), .data_in(din), .read_en_n(ren_n),
    .data_out(dout), .data_out_oe(oe), .flags(flags));
  fdc_ring_model #(.DLY(5)) i_wring (.clk(clk), .srst(srst), .tok_out(wto), .tok_in(wti));
  fdc_ring_model #(.DLY(20)) i_rring (.clk(clk), .srst(srst), .tok_out(rto), .tok_in(rti));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string n, logic [17:0] e, logic [17:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(int n, bit keep);
    repeat (n) begin
      @(negedge clk);
      wen_n = 0;
      din = $random(seed);
      if (keep) exp_q.push_back(din);
    end
    @(negedge clk) wen_n = 1;
  endtask
  task automatic rd(int n);
    repeat (n) @(negedge clk) ren_n = 0;
    @(negedge clk) ren_n = 1;
  endtask
  // read history and token pulse counts
  always @(posedge clk) begin
    if (srst) begin
      {rh, wcnt, rcnt} <= {3'h0, 18'h0, 18'h0};
    end else begin
      rh <= {rh[1:0], ~ren_n};
      wcnt <= wcnt + 18'(wto);
      rcnt <= rcnt + 18'(rto);
    end
  end
  // watcher pops the oldest note per read strobe driven three edges before
  always @(negedge clk) if (rh[2] && exp_q.size() > 0) begin
    chk("data", exp_q.pop_front(), dout);
    chk("oe", 18'h1, 18'(oe));
  end
  initial begin
    {seed, errors, compares} = {32'h3B, 32'h0, 32'h0};
    {srst, fds, wen_n, ren_n, ld, din} = {5'h16, 18'h0};
    repeat (8) @(negedge clk);
    srst = 0;
    repeat (3) @(negedge clk);
    chk("rst", 18'hA, 18'(flags));
    // program empty then full offset on the shared load line, read both back
    @(negedge clk) ld = 1;
    @(negedge clk) {wen_n, din} = {1'h0, 18'h2};
    @(negedge clk) din = 18'h3;
    @(negedge clk) wen_n = 1;
    exp_q.push_back(18'h2);
    exp_q.push_back(18'h3);
    rd(2);
    repeat (4) @(negedge clk);
    ld = 0;
    repeat (3) @(negedge clk);
    wr(8, 1);
    wr(1, 0);
    repeat (4) @(negedge clk);
    chk("full", 18'h5, 18'(flags));
    rd(9);
    repeat (30) @(negedge clk);
    chk("empty", 18'hA, 18'(flags));
    wr(3, 1);
    repeat (4) @(negedge clk);
    chk("mid", 18'hF, 18'(flags));
    rd(3);
    repeat (30) @(negedge clk);
    chk("wtok", 18'h1, wcnt);
    chk("rtok", 18'h2, rcnt);
    {srst, fds} = 2'h3;
    repeat (8) @(negedge clk);
    srst = 0;
    repeat (3) @(negedge clk);
    wr(2, 0);
    rd(1);
    repeat (4) @(negedge clk);
    chk("other", 18'hA, 18'(flags));
    chk("oe_off", 18'h0, 18'(oe));
    stop_test();
  end
endmodule // fdc_cascade_tb
bind fdc_cascade fdc_cascade_properties i_props (.clk(clk), .srst(srst),
  .write_token_out(write_token_out), .read_token_out(read_token_out),
  .data_out_oe(data_out_oe), .flags(flags));
